// ===== core/atp_pkg.sv
package atp_pkg;

	// ----------------------------------------------------------------
	// Register map (APB byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_CTRL      = 8'h00;
	localparam logic [7:0]  ADDR_PACER_DIV = 8'h04;
	localparam logic [7:0]  ADDR_GP_DIV    = 8'h08;
	localparam logic [7:0]  ADDR_CHAN_CFG  = 8'h0C;
	localparam logic [7:0]  ADDR_STATUS    = 8'h10;
	localparam logic [7:0]  ADDR_GP_COUNT  = 8'h14;

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	localparam int CTRL_TRIG_SRC  = 0;  // 0 pacer, 1 external
	localparam int CTRL_PACER_EN  = 1;
	localparam int CTRL_PACER_OE  = 2;
	localparam int CTRL_GP_EXTCLK = 3;
	localparam int CTRL_GP_PULSE  = 4;
	localparam int CTRL_GP_EN     = 5;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [5:0]  CTRL_RESET      = 6'h00;
	localparam logic [31:0] PACER_DIV_RESET = 32'h0000_0064;
	localparam logic [15:0] GP_DIV_RESET    = 16'h000A;
	localparam logic [7:0]  CHAN_CFG_RESET  = 8'h00;
	localparam int          CLK_HZ          = 100_000_000;
	localparam int          TB_HZ           = 10_000_000;
	localparam logic [3:0]  TB_TICKS        = 4'(CLK_HZ / TB_HZ);
	localparam logic [4:0]  MAX_CHANNELS    = 5'h10;

	typedef enum logic {ATP_SRC_PACER, ATP_SRC_EXT} atp_src_t;

	// Registered pin outputs, carried together
	typedef struct packed {
		logic conv_start;
		logic pacer_out;
		logic gp_out;
	} atp_pins_t;

endpackage : atp_pkg

// ===== core/atp_trigger_pacer.sv
// Summary of operation
// R1: Three 16-bit counters on 10 MHz timebase
// R2: Counters one and two form 32-bit pacer
// R3: Pacer rising edge starts one conversion
// R4: Pacer pin pulses once per period (never here if the high half is 0 or 1)
// R5: External trigger rising edge starts conversion
// R6: Low trigger gate blocks external trigger
// R7: Counter zero clock: pin or timebase
// R8: Counter zero counts events or pulses, gated
// R9: Each channel pair single-ended or differential
// R10: All differential gives at most eight channels
// R11: Only selected source triggers; inputs synchronised
//
// The APB interface to the registers and the register addresses are this design's own decisions.
module atp_trigger_pacer
(
	// Clock and reset
	input  wire logic             CLOCK,
	input  wire logic             RESET,
	// APB slave
	input  wire logic             PSEL,
	input  wire logic             PENABLE,
	input  wire logic             PWRITE,
	input  wire logic [7:0]       PADDR,
	input  wire logic [31:0]      PWDATA,
	output logic      [31:0]      PRDATA,
	output logic                  PREADY,
	output logic                  PSLVERR,
	// External pins
	input  wire logic             GP_COUNTER_CLOCK_IN,
	input  wire logic             GP_COUNTER_GATE,
	input  wire logic             EXT_TRIGGER_GATE,
	input  wire logic             EXT_CONVERSION_TRIGGER,
	output atp_pkg::atp_pins_t    PINS,
	// Channel sequencing
	output logic      [4:0]       CHANNEL_COUNT
);
	import atp_pkg::*;

	logic [5:0]  ctrl_q;
	logic [31:0] pacer_div_q;
	logic [15:0] gp_div_q;
	logic [7:0]  chan_cfg_q;
	logic [3:0]  tb_cnt_q;
	logic        tb_tick;
	logic [2:0]  sync1_q;
	logic [2:0]  sync2_q;
	logic [2:0]  sync3_q;
	logic        ext_rise;
	logic        gp_clk_rise;
	logic [15:0] cnt1_q;
	logic [15:0] cnt2_q;
	logic        cnt2_out_q;
	logic        cnt2_out_prev_q;
	logic        pacer_rise;
	logic [15:0] gp_count_q;
	logic [15:0] gp_reload_q;
	logic        gp_out_q;
	logic        gate_sync1_q;
	logic        gate_sync2_q;
	logic        gp_tick;
	logic        conv_q;
	logic        pacer_pulse_q;
	logic [31:0] rdata_d;
	logic        wr_en;

	// Decode the register-offset hit used by reads and writes
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : hit

	// ----------------------------------------------------------------
	// APB register file
	// ----------------------------------------------------------------
	assign wr_en   = PSEL && PENABLE && PWRITE;
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !(hit(PADDR, ADDR_CTRL)
		|| hit(PADDR, ADDR_PACER_DIV) || hit(PADDR, ADDR_GP_DIV)
		|| hit(PADDR, ADDR_CHAN_CFG) || hit(PADDR, ADDR_STATUS)
		|| hit(PADDR, ADDR_GP_COUNT));

	// Writable configuration; read-only words ignore writes
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			ctrl_q      <= CTRL_RESET;
			pacer_div_q <= PACER_DIV_RESET;
			gp_div_q    <= GP_DIV_RESET;
			chan_cfg_q  <= CHAN_CFG_RESET;
		end
		else if (wr_en)
		begin
			if (hit(PADDR, ADDR_CTRL))
				ctrl_q <= PWDATA[5:0];
			if (hit(PADDR, ADDR_PACER_DIV))
				pacer_div_q <= PWDATA;
			if (hit(PADDR, ADDR_GP_DIV))
				gp_div_q <= PWDATA[15:0];
			if (hit(PADDR, ADDR_CHAN_CFG))
				chan_cfg_q <= PWDATA[7:0]; // [R9]
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (hit(PADDR, ADDR_CTRL))
			rdata_d = {26'h0, ctrl_q};
		else if (hit(PADDR, ADDR_PACER_DIV))
			rdata_d = pacer_div_q;
		else if (hit(PADDR, ADDR_GP_DIV))
			rdata_d = {16'h0, gp_div_q};
		else if (hit(PADDR, ADDR_CHAN_CFG))
			rdata_d = {24'h0, chan_cfg_q};
		else if (hit(PADDR, ADDR_STATUS))
			rdata_d = {22'h0, CHANNEL_COUNT, gp_out_q, cnt2_out_q, sync2_q};
		else if (hit(PADDR, ADDR_GP_COUNT))
			rdata_d = {16'h0, gp_count_q};
	end

	// Read data registered so it is a flop output; valid in access phase
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
			PRDATA <= 32'h0000_0000;
		else if (PSEL && !PENABLE)
			PRDATA <= rdata_d;
	end

	// ----------------------------------------------------------------
	// Timebase and pin synchronisers
	// ----------------------------------------------------------------
	// Divide the system clock down to the 10 MHz count rate
	always_ff @(posedge CLOCK)
	begin
		if (RESET || tb_tick)
			tb_cnt_q <= 4'h0;
		else
			tb_cnt_q <= tb_cnt_q + 4'h1;
	end
	assign tb_tick = (tb_cnt_q == TB_TICKS - 4'h1); // [R1]

	// Two flops per pin, third stage only for edge detection
	// Bits: 0 ext trigger, 1 trigger gate, 2 gp clock
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			sync3_q <= 3'h0;
		end
		else
		begin
			sync1_q <= {GP_COUNTER_CLOCK_IN, EXT_TRIGGER_GATE, EXT_CONVERSION_TRIGGER};
			sync2_q <= sync1_q; // [R11]
			sync3_q <= sync2_q;
		end
	end
	assign ext_rise    = sync2_q[0] && !sync3_q[0]; // [R5]
	assign gp_clk_rise = sync2_q[2] && !sync3_q[2];

	// ----------------------------------------------------------------
	// Pacer: counters one and two cascaded
	// ----------------------------------------------------------------
	// Counter one divides by the low half; each wrap steps counter two.
	// With a high half of 2 or more, counter two output is high for the second
	// half of its count, so it makes exactly one rising edge per full pacer period.
	always_ff @(posedge CLOCK)
	begin
		if (RESET || !ctrl_q[CTRL_PACER_EN])
		begin
			cnt1_q     <= 16'h0000;
			cnt2_q     <= 16'h0000;
			cnt2_out_q <= 1'b0;
		end
		else if (tb_tick)
		begin
			if (cnt1_q <= 16'h0001)
			begin
				cnt1_q <= (pacer_div_q[15:0] == 16'h0000) ? 16'hFFFF
					: pacer_div_q[15:0]; // [R2]
				if (cnt2_q <= 16'h0001)
				begin
					cnt2_q     <= pacer_div_q[31:16] == 16'h0000 ? 16'h0001
						: pacer_div_q[31:16];
					cnt2_out_q <= 1'b0;
				end
				else
				begin
					cnt2_q     <= cnt2_q - 16'h0001;
					cnt2_out_q <= (cnt2_q - 16'h0001) <= (pacer_div_q[31:16] >> 1);
				end
			end
			else
				cnt1_q <= cnt1_q - 16'h0001; // [R1]
		end
	end

	// Edge detect on counter two output
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
			cnt2_out_prev_q <= 1'b0;
		else
			cnt2_out_prev_q <= cnt2_out_q;
	end
	assign pacer_rise = cnt2_out_q && !cnt2_out_prev_q;

	// ----------------------------------------------------------------
	// Conversion start and pacer pin
	// ----------------------------------------------------------------
	// One-cycle start pulse from the selected source only
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
			conv_q <= 1'b0;
		else if (ctrl_q[CTRL_TRIG_SRC] == ATP_SRC_EXT)
			conv_q <= ext_rise && sync2_q[1]; // [R6] [R11]
		else
			conv_q <= pacer_rise; // [R3]
	end

	// Pin pulses once per period while enabled and the high half is 2 or more
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
			pacer_pulse_q <= 1'b0;
		else
			pacer_pulse_q <= ctrl_q[CTRL_PACER_OE] && pacer_rise; // [R4]
	end

	// ----------------------------------------------------------------
	// General-purpose counter zero
	// ----------------------------------------------------------------
	// Event mode counts up; pulse mode reloads and toggles its output
	always_ff @(posedge CLOCK)
	begin
		if (RESET || !ctrl_q[CTRL_GP_EN])
		begin
			gp_count_q  <= 16'h0000;
			gp_reload_q <= 16'h0000;
			gp_out_q    <= 1'b0;
		end
		else if (gp_tick)
		begin
			if (!ctrl_q[CTRL_GP_PULSE])
				gp_count_q <= gp_count_q + 16'h0001; // [R8]
			else if (gp_reload_q <= 16'h0001)
			begin
				gp_reload_q <= (gp_div_q == 16'h0000) ? 16'h0001 : gp_div_q;
				gp_out_q    <= !gp_out_q; // [R8]
			end
			else
				gp_reload_q <= gp_reload_q - 16'h0001;
		end
	end

	// Separate synchroniser for the counter gate pin
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			gate_sync1_q <= 1'b0;
			gate_sync2_q <= 1'b0;
		end
		else
		begin
			gate_sync1_q <= GP_COUNTER_GATE;
			gate_sync2_q <= gate_sync1_q;
		end
	end
	// Clock select: synchronised pin edge or internal timebase. The gate
	// passes the same depth of flops as the pin clock, so a gate window
	// of N cycles lets through exactly the pin edges that fall inside it
	assign gp_tick = (ctrl_q[CTRL_GP_EXTCLK] ? gp_clk_rise : tb_tick)
		&& gate_sync2_q; // [R7] [R8]

	// ----------------------------------------------------------------
	// Channel count and outputs
	// ----------------------------------------------------------------
	// Each differential pair removes one channel: 16 down to 8
	always_comb
	begin
		CHANNEL_COUNT = MAX_CHANNELS;
		for (int i = 0; i < 8; i++)
			CHANNEL_COUNT = CHANNEL_COUNT - {4'h0, chan_cfg_q[i]}; // [R10]
	end

	assign PINS = '{conv_start: conv_q, pacer_out: pacer_pulse_q, gp_out: gp_out_q};

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Nine quiet cycles between two timebase ticks
	sequence s_tb_gap;
		!tb_tick [*8] ##1 !tb_tick;
	endsequence : s_tb_gap

	// A synchronised external edge that both gate and source allow
	sequence s_ext_allowed;
		ext_rise && sync2_q[1] && ctrl_q[CTRL_TRIG_SRC] == ATP_SRC_EXT;
	endsequence : s_ext_allowed

	a_conv_src_pacer: assert property (@(posedge CLOCK) disable iff (RESET) // [R3]
		(pacer_rise && ctrl_q[CTRL_TRIG_SRC] == ATP_SRC_PACER) |=> conv_q)
		else $error("pacer edge did not start conversion");
	a_ext_gated: assert property (@(posedge CLOCK) disable iff (RESET) // [R6]
		(!sync2_q[1] && ctrl_q[CTRL_TRIG_SRC] == ATP_SRC_EXT) |=> !conv_q)
		else $error("conversion started while gate low");
	a_ext_start: assert property (@(posedge CLOCK) disable iff (RESET) // [R5]
		s_ext_allowed |=> conv_q)
		else $error("external edge did not start conversion");
	a_pin_one_pulse: assert property (@(posedge CLOCK) disable iff (RESET) // [R4]
		pacer_pulse_q |=> !pacer_pulse_q)
		else $error("pacer pin pulse too long");
	a_conv_single: assert property (@(posedge CLOCK) disable iff (RESET) // [R11]
		conv_q |=> !conv_q)
		else $error("conversion start longer than one cycle");
	a_tb_period: assert property (@(posedge CLOCK) disable iff (RESET) // [R1]
		tb_tick |=> s_tb_gap ##1 tb_tick)
		else $error("timebase period wrong");
	a_chan_min: assert property (@(posedge CLOCK) disable iff (RESET) // [R10]
		(chan_cfg_q == 8'hFF) |-> CHANNEL_COUNT == 5'h08)
		else $error("all differential must give eight channels");
	a_gp_hold: assert property (@(posedge CLOCK) disable iff (RESET) // [R8]
		(!gate_sync2_q && ctrl_q[CTRL_GP_EN] && $past(ctrl_q[CTRL_GP_EN])) |=> $stable(gp_count_q))
		else $error("counter moved with gate low");

	// Source selection and pacer enable
	a_src_ext_only: assert property (@(posedge CLOCK) disable iff (RESET) // [R11]
		(ctrl_q[CTRL_TRIG_SRC] == ATP_SRC_EXT && !ext_rise) |=> !conv_q)
		else $error("conversion started without external edge");
	a_pacer_off: assert property (@(posedge CLOCK) disable iff (RESET) // [R2]
		!ctrl_q[CTRL_PACER_EN] |=> !cnt2_out_q)
		else $error("pacer output high while disabled");
	a_pin_follows: assert property (@(posedge CLOCK) disable iff (RESET) // [R4]
		(ctrl_q[CTRL_PACER_OE] && pacer_rise) |=> pacer_pulse_q)
		else $error("pacer pin missed a period");

	// Event counting and channel count
	a_gp_events: assert property (@(posedge CLOCK) disable iff (RESET) // [R8]
		(ctrl_q[CTRL_GP_EN] && !ctrl_q[CTRL_GP_PULSE] && gp_tick)
		|=> gp_count_q == $past(gp_count_q) + 16'h0001)
		else $error("event counter missed a step");
	a_chan_full: assert property (@(posedge CLOCK) disable iff (RESET) // [R9]
		(chan_cfg_q == 8'h00) |-> CHANNEL_COUNT == MAX_CHANNELS)
		else $error("all single-ended must give sixteen channels");

endmodule : atp_trigger_pacer

// ===== verification/atp_ext_source.sv
// ----------------------------------------------------------------
// Far side: trigger source and converter start counter
// ----------------------------------------------------------------
module atp_ext_source
(
	// Clock
	input  wire logic          clk,
	// Pins
	input  wire atp_pkg::atp_pins_t pins,
	output logic               trig,
	output logic               gate
);
	timeunit 1ns;
	timeprecision 1ps;
	import atp_pkg::*;

	int starts;

	// Converter side counts every start pulse it sees
	always @(posedge clk)
		if (pins.conv_start === 1'b1)
			starts++;

	initial
	begin
		trig   = 1'b0;
		gate   = 1'b1;
		starts = 0;
	end

	// Gate level is set by the bench; low mutes the source while the external trigger source is selected
	task set_gate(input logic g);
		@(posedge clk);
		gate <= g;
	endtask : set_gate

	// One clean rising edge, held long enough for the two-flop synchroniser
	task fire();
		@(posedge clk);
		trig <= 1'b1;
		repeat (4) @(posedge clk);
		trig <= 1'b0;
	endtask : fire
endmodule : atp_ext_source

// ===== verification/atp_trigger_pacer_tb.sv
module atp_trigger_pacer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import atp_pkg::*;

	logic clk, rst, psel, penable, pwrite, gclk, ggate, gclk_on;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic pready, pslverr, e, trig, gate;
	logic [4:0] chan;
	atp_pins_t pins;
	int failures, n_checks, gdiv;

	// ----------------------------------------------------------------
	// Clock, stimulus and instances
	// ----------------------------------------------------------------
	always #5 clk = ~clk;

	// External counter clock, period 20 cycles, only when switched on
	always @(posedge clk)
	begin
		gdiv <= (gdiv == 9) ? 0 : gdiv + 1;
		if (gclk_on && gdiv == 9)
			gclk <= ~gclk;
	end

	atp_trigger_pacer i_atp_trigger_pacer (.CLOCK(clk), .RESET(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.GP_COUNTER_CLOCK_IN(gclk), .GP_COUNTER_GATE(ggate),
		.EXT_TRIGGER_GATE(gate), .EXT_CONVERSION_TRIGGER(trig),
		.PINS(pins), .CHANNEL_COUNT(chan));
	atp_ext_source i_atp_ext_source (.clk(clk), .pins(pins), .trig(trig), .gate(gate));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task wrap_up();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask : chk

	// Request held until pready is sampled high; data taken at that edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		if (i >= 20)
		begin
			failures++;
			wrap_up();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb

	// Cycles between two rising edges of one pin bit, bounded
	task period(input int b, input int x, input string nm);
		int n;
		logic p;
		n = -1;
		p = pins[b];
		repeat (3000)
		begin
			@(posedge clk);
			if (pins[b] === 1'b1 && p !== 1'b1)
			begin
				if (n >= 0)
					break;
				n = 0;
			end
			else if (n >= 0)
				n++;
			p = pins[b];
		end
		chk(nm, x, n + 1);
	endtask : period

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset_map();
		logic [7:0] a[4] = '{ADDR_CTRL, ADDR_PACER_DIV, ADDR_GP_DIV, ADDR_CHAN_CFG};
		logic [31:0] v[4] = '{32'(CTRL_RESET), PACER_DIV_RESET, 32'(GP_DIV_RESET), 32'h0};
		chk("chan reset", 32'h10, 32'(chan));
		foreach (a[k])
		begin
			apb(1'b0, a[k], 32'h0);
			chk("reset value", v[k], r);
		end
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped err", 32'h1, 32'(e));
	endtask : t_reset_map

	task t_channels();
		// The write lands at the access edge; look one edge later
		apb(1'b1, ADDR_CHAN_CFG, 32'h05);
		@(posedge clk);
		chk("two pairs diff", 32'd14, 32'(chan));
		apb(1'b1, ADDR_CHAN_CFG, 32'hFF);
		@(posedge clk);
		chk("all diff", 32'd8, 32'(chan));
		// Status: eight channels, outputs low, gate pin high
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("status word", 32'h0000_0102, r);
	endtask : t_channels

	// 2 x 3 timebase ticks = 60 clock cycles between starts
	task t_pacer();
		apb(1'b1, ADDR_PACER_DIV, 32'h0003_0002);
		apb(1'b1, ADDR_CTRL, 32'h06);
		period(2, 60, "pacer start");
		period(1, 60, "pacer pin");
	endtask : t_pacer

	task t_external();
		int s;
		apb(1'b1, ADDR_CTRL, 32'h07);
		repeat (70) @(posedge clk);
		s = i_atp_ext_source.starts;
		i_atp_ext_source.fire();
		repeat (10) @(posedge clk);
		chk("ext start", s + 1, i_atp_ext_source.starts);
		i_atp_ext_source.set_gate(1'b0);
		i_atp_ext_source.fire();
		repeat (10) @(posedge clk);
		chk("gated start", s + 1, i_atp_ext_source.starts);
		i_atp_ext_source.set_gate(1'b1);
	endtask : t_external

	// Toggle every 2 counts: 40 cycles on the timebase, 80 on the pin clock
	task t_gp();
		apb(1'b1, ADDR_GP_DIV, 32'h2);
		apb(1'b1, ADDR_CTRL, 32'h30);
		period(0, 40, "gp internal");
		gclk_on <= 1'b1;
		apb(1'b1, ADDR_CTRL, 32'h38);
		period(0, 80, "gp pin clock");
		// Event mode on the pin clock: nothing counts while the gate is low
		ggate <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'h00);
		apb(1'b1, ADDR_CTRL, 32'h28);
		repeat (100) @(posedge clk);
		apb(1'b0, ADDR_GP_COUNT, 32'h0);
		chk("gp gated count", 32'h0, r);
		// 100 open cycles hold exactly five pin-clock edges (period 20)
		ggate <= 1'b1;
		repeat (100) @(posedge clk);
		ggate <= 1'b0;
		repeat (10) @(posedge clk);
		apb(1'b0, ADDR_GP_COUNT, 32'h0);
		chk("gp events", 32'h5, r);
		repeat (60) @(posedge clk);
		apb(1'b0, ADDR_GP_COUNT, 32'h0);
		chk("gp held", 32'h5, r);
	endtask : t_gp

	initial
	begin
		clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		gclk = 0; ggate = 1; gclk_on = 0; gdiv = 0; failures = 0; n_checks = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset_map();
		t_channels();
		t_pacer();
		t_external();
		t_gp();
		wrap_up();
	end
endmodule : atp_trigger_pacer_tb
